/* design/flash_seq_pkg.sv */
package flash_seq_pkg;
    // Command opcodes
    localparam logic [7:0] OPC_SEQ_A         = 8'had;
    localparam logic [7:0] OPC_SEQ_B         = 8'haf;
    localparam logic [7:0] OPC_PAGE_ERASE    = 8'h81;
    localparam logic [7:0] OPC_ERASE_4K      = 8'h20;
    localparam logic [7:0] OPC_ERASE_32K     = 8'h52;
    localparam logic [7:0] OPC_ERASE_64K     = 8'hd8;
    localparam logic [7:0] OPC_STATUS_IRQ    = 8'h25;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;

    // Array geometry
    localparam int          ADDR_W      = 19;
    localparam logic [18:0] TOP_ADDR    = 19'h7ffff;
    localparam int          SECTOR_LSB  = 16;
    localparam int          NUM_SECTORS = 8;
    localparam logic [18:0] MASK_4K     = 19'h7f000;
    localparam logic [18:0] MASK_32K    = 19'h78000;
    localparam logic [18:0] MASK_64K    = 19'h70000;
    localparam int          PAGE_LSB    = 8;

    // Frame byte counts (opcode included)
    localparam logic [2:0] SEQ_FIRST_BYTES = 3'h5;
    localparam logic [2:0] SEQ_NEXT_BYTES  = 3'h2;
    localparam logic [2:0] ERASE_BYTES     = 3'h4;
    localparam logic [2:0] OPC_ONLY_BYTES  = 3'h1;
    localparam logic [2:0] STATUS_IRQ_BYTES = 3'h2;
    localparam logic [2:0] IDX_MAX         = 3'h7;

    // Command queue
    localparam int FIFO_DEPTH = 16;
    localparam int OP_W       = 3;
    localparam int CMD_W      = OP_W + ADDR_W + 8;

    typedef enum logic [2:0] {
        ARR_PROGRAM,
        ARR_ERASE_PAGE,
        ARR_ERASE_4K,
        ARR_ERASE_32K,
        ARR_ERASE_64K
    } array_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_ISSUE
    } frame_state_t;
endpackage

/* design/cmd_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wr_q;
    logic [PW:0]      rd_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Full when pointers differ only in the wrap bit
    assign in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[PW-1:0]];

    // Pointer update
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end

    // Storage write
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q[PW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

/* design/spi_byte_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_byte_rx (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Link pins
    input  wire logic       cs_n_pin,
    input  wire logic       sclk_pin,
    input  wire logic       si_pin,
    // Decoded events
    output logic            frame_start,
    output logic            frame_end,
    output logic            byte_valid,
    output logic      [7:0] byte_data,
    output logic      [2:0] bit_cnt
);
    logic [2:0] cs_q;
    logic [2:0] sclk_q;
    logic [1:0] si_q;
    logic [6:0] sh_q;

    // Edges look only at second and third stages
    wire sclk_rise = sclk_q[1] && !sclk_q[2] && !cs_q[1];
    assign frame_start = !cs_q[1] && cs_q[2];
    assign frame_end   = cs_q[1] && !cs_q[2];

    // Two-stage synchronisers plus edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_q   <= 3'h7;
            sclk_q <= 3'h0;
            si_q   <= 2'h0;
        end else begin
            cs_q   <= {cs_q[1:0], cs_n_pin};
            sclk_q <= {sclk_q[1:0], sclk_pin};
            si_q   <= {si_q[0], si_pin};
        end
    end

    // Shift MSB first on each rising link clock
    always_ff @(posedge clk) begin
        if (reset) begin
            sh_q       <= 7'h00;
            bit_cnt    <= 3'h0;
            byte_valid <= 1'b0;
            byte_data  <= 8'h00;
        end else begin
            byte_valid <= 1'b0;
            if (frame_start) begin
                bit_cnt <= 3'h0;
            end else if (sclk_rise) begin
                sh_q    <= {sh_q[5:0], si_q[1]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    byte_valid <= 1'b1;
                    byte_data  <= {sh_q, si_q[1]};
                end
            end
        end
    end
endmodule
`default_nettype wire

/* design/flash_seq_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_seq_ctrl (
    // Clock and reset
    input  wire logic                                  SYS_CLK,
    input  wire logic                                  RESET,
    // Serial link
    input  wire logic                                  CS_N,
    input  wire logic                                  SCLK,
    input  wire logic                                  SI,
    output logic                                       SO,
    output logic                                       SO_OE,
    // Sector protection
    input  wire logic [flash_seq_pkg::NUM_SECTORS-1:0] SECTOR_PROTECT,
    // Array core
    output logic                                       ARRAY_VALID,
    input  wire logic                                  ARRAY_READY,
    output logic      [flash_seq_pkg::OP_W-1:0]        ARRAY_OP,
    output logic      [flash_seq_pkg::ADDR_W-1:0]      ARRAY_ADDR,
    output logic      [7:0]                            ARRAY_DATA,
    input  wire logic                                  ARRAY_DONE,
    input  wire logic                                  ARRAY_FAIL,
    // Status
    input  wire logic                                  ERROR_CLEAR,
    output logic                                       WRITE_ENABLE_LATCH,
    output logic                                       PROGRAM_ERASE_ERROR_FLAG,
    output logic                                       BUSY,
    output logic                                       SEQ_MODE
);
    localparam int AW = flash_seq_pkg::ADDR_W;
    localparam int SL = flash_seq_pkg::SECTOR_LSB;

    flash_seq_pkg::frame_state_t state_q;
    flash_seq_pkg::frame_state_t state_d;

    logic [7:0]    op_q;
    logic [2:0]    idx_q;
    logic [23:0]   addr_q;
    logic [7:0]    data_q;
    logic [AW-1:0] cnt_q;
    logic          wel_q;
    logic          seq_q;
    logic          epe_q;
    logic          infl_q;
    logic          so_q;
    logic          so_oe_q;
    logic [flash_seq_pkg::CMD_W-1:0] word_q;

    logic       rx_start;
    logic       rx_end;
    logic       rx_byte;
    logic [7:0] rx_data;
    logic [2:0] rx_bits;
    logic       q_ready;
    logic       q_valid;
    logic [flash_seq_pkg::CMD_W-1:0] q_data;

    // Byte receiver on the synchronised link
    spi_byte_rx u_rx (
        .clk         (SYS_CLK),
        .reset       (RESET),
        .cs_n_pin    (CS_N),
        .sclk_pin    (SCLK),
        .si_pin      (SI),
        .frame_start (rx_start),
        .frame_end   (rx_end),
        .byte_valid  (rx_byte),
        .byte_data   (rx_data),
        .bit_cnt     (rx_bits)
    );

    // Queue of accepted array operations
    cmd_fifo #(
        .WIDTH (flash_seq_pkg::CMD_W),
        .DEPTH (flash_seq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .reset     (RESET),
        .in_valid  (state_q == flash_seq_pkg::ST_ISSUE),
        .in_ready  (q_ready),
        .in_data   (word_q),
        .out_valid (q_valid),
        .out_ready (ARRAY_READY),
        .out_data  (q_data)
    );

    // Opcode decode
    wire is_seq  = (op_q == flash_seq_pkg::OPC_SEQ_A) || (op_q == flash_seq_pkg::OPC_SEQ_B);
    wire is_pe   = (op_q == flash_seq_pkg::OPC_PAGE_ERASE);
    wire is_4k   = (op_q == flash_seq_pkg::OPC_ERASE_4K);
    wire is_32k  = (op_q == flash_seq_pkg::OPC_ERASE_32K);
    wire is_64k  = (op_q == flash_seq_pkg::OPC_ERASE_64K);
    wire is_er   = is_pe || is_4k || is_32k || is_64k;
    wire is_wd   = (op_q == flash_seq_pkg::OPC_WRITE_DISABLE);
    wire is_we   = (op_q == flash_seq_pkg::OPC_WRITE_ENABLE);
    wire is_irq  = (op_q == flash_seq_pkg::OPC_STATUS_IRQ);
    wire aligned = (rx_bits == 3'h0);
    wire in_shift = (state_q == flash_seq_pkg::ST_SHIFT);
    wire decide  = in_shift && rx_end;

    // Sequential cycle checks
    wire [AW-1:0] seq_addr = seq_q ? cnt_q : addr_q[AW-1:0];
    wire [AW-1:0] seq_next = seq_addr + 19'h00001;
    wire first_ok = is_seq && !seq_q && wel_q && aligned
                    && (idx_q >= flash_seq_pkg::SEQ_FIRST_BYTES);
    wire next_ok  = is_seq && seq_q && aligned
                    && (idx_q >= flash_seq_pkg::SEQ_NEXT_BYTES);
    wire first_prot = SECTOR_PROTECT[seq_addr[AW-1:SL]];
    wire seq_go   = (first_ok && !first_prot) || next_ok;
    wire seq_bad  = is_seq && (seq_q || wel_q) && !first_ok && !next_ok;
    wire seq_last = (seq_addr == flash_seq_pkg::TOP_ADDR)
                    || SECTOR_PROTECT[seq_next[AW-1:SL]];

    // Erase address forming and checks
    wire [AW-1:0] pe_addr = {3'h0, addr_q[15:8], 8'h00};
    wire [AW-1:0] blk_mask = is_4k  ? flash_seq_pkg::MASK_4K :
                             is_32k ? flash_seq_pkg::MASK_32K :
                                      flash_seq_pkg::MASK_64K;
    wire [AW-1:0] er_addr = is_pe ? pe_addr : (addr_q[AW-1:0] & blk_mask);
    wire er_ok   = is_er && wel_q && aligned
                   && (idx_q >= flash_seq_pkg::ERASE_BYTES);
    wire er_prot = SECTOR_PROTECT[er_addr[AW-1:SL]];
    wire er_go   = er_ok && !er_prot;
    wire er_bad  = is_er && wel_q && !er_ok;
    wire opc_ok  = aligned && (idx_q >= flash_seq_pkg::OPC_ONLY_BYTES);
    wire wd_ok   = is_wd && opc_ok;
    wire we_ok   = is_we && opc_ok;

    // Operation word for the array queue
    wire flash_seq_pkg::array_op_t er_op =
        is_pe  ? flash_seq_pkg::ARR_ERASE_PAGE :
        is_4k  ? flash_seq_pkg::ARR_ERASE_4K :
        is_32k ? flash_seq_pkg::ARR_ERASE_32K : flash_seq_pkg::ARR_ERASE_64K;
    wire [flash_seq_pkg::CMD_W-1:0] word_d = seq_go ?
        {flash_seq_pkg::ARR_PROGRAM, seq_addr, data_q} : {er_op, er_addr, 8'hff};
    wire go = seq_go || er_go;

    // Latch and mode next values, taken at frame end
    wire wel_clr = wd_ok || seq_bad || (first_ok && first_prot) || er_bad
                   || (er_ok && er_prot) || er_go || (seq_go && seq_last);
    wire seq_clr = wd_ok || seq_bad || (seq_go && seq_last);

    // Status drive for the active status opcode
    wire irq_active = in_shift && is_irq && (idx_q >= flash_seq_pkg::STATUS_IRQ_BYTES);

    assign BUSY = (state_q == flash_seq_pkg::ST_ISSUE) || q_valid || infl_q;
    assign ARRAY_VALID = q_valid;
    assign {ARRAY_OP, ARRAY_ADDR, ARRAY_DATA} = q_data;
    assign WRITE_ENABLE_LATCH = wel_q;
    assign PROGRAM_ERASE_ERROR_FLAG = epe_q;
    assign SEQ_MODE = seq_q;
    assign SO = so_q;
    assign SO_OE = so_oe_q;

    // Frame state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            flash_seq_pkg::ST_IDLE: begin
                if (rx_start) state_d = flash_seq_pkg::ST_SHIFT;
            end
            flash_seq_pkg::ST_SHIFT: begin
                if (rx_end) state_d = go ? flash_seq_pkg::ST_ISSUE : flash_seq_pkg::ST_IDLE;
            end
            flash_seq_pkg::ST_ISSUE: begin
                if (q_ready) state_d = flash_seq_pkg::ST_IDLE;
            end
            default: state_d = flash_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) state_q <= flash_seq_pkg::ST_IDLE;
        else state_q <= state_d;
    end

    // Opcode, address and data capture per byte
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            op_q   <= 8'h00;
            idx_q  <= 3'h0;
            addr_q <= 24'h000000;
            data_q <= 8'h00;
        end else if (rx_start) begin
            idx_q <= 3'h0;
        end else if (rx_byte && in_shift) begin
            if (idx_q != flash_seq_pkg::IDX_MAX) idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h0) op_q <= rx_data;
            if (idx_q >= 3'h1 && idx_q <= 3'h3 && !(is_seq && seq_q))
                addr_q <= {addr_q[15:0], rx_data};
            if (is_seq && (seq_q || idx_q >= 3'h4)) data_q <= rx_data;
        end
    end

    // Write enable latch and sequential mode
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            wel_q  <= 1'b0;
            seq_q  <= 1'b0;
            cnt_q  <= '0;
            word_q <= '0;
        end else if (decide) begin
            if (wel_clr) wel_q <= 1'b0;
            else if (we_ok) wel_q <= 1'b1;
            if (seq_clr) seq_q <= 1'b0;
            else if (seq_go) seq_q <= 1'b1;
            if (seq_go) cnt_q <= seq_next;
            if (go) word_q <= word_d;
        end
    end

    // Array progress and error flag; a set beats a clear
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            infl_q <= 1'b0;
            epe_q  <= 1'b0;
        end else begin
            if (q_valid && ARRAY_READY) infl_q <= 1'b1;
            else if (ARRAY_DONE) infl_q <= 1'b0;
            if (ARRAY_DONE && ARRAY_FAIL) epe_q <= 1'b1;
            else if (ERROR_CLEAR) epe_q <= 1'b0;
        end
    end

    // Serial output while the status opcode is active: high while busy, low once idle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_oe_q <= irq_active && !rx_end;
            so_q    <= irq_active && BUSY;
        end
    end

    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_first_frame;
        decide && first_ok && !first_prot;
    endsequence
    sequence s_issue_seen;
        state_q == flash_seq_pkg::ST_ISSUE && BUSY;
    endsequence

    property p_first;
        s_first_frame |=> s_issue_seen ##0 word_q[AW+7:8] == $past(addr_q[AW-1:0]);
    endproperty
    a_first: assert property (p_first) else $error("first byte not queued");

    property p_next;
        decide && next_ok |=> cnt_q == $past(cnt_q) + 19'h00001;
    endproperty
    a_next: assert property (p_next) else $error("counter did not step");

    property p_abort;
        decide && seq_bad |=> !wel_q && !seq_q && state_q == flash_seq_pkg::ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("abort kept latch");

    property p_prot;
        decide && first_ok && first_prot |=> state_q == flash_seq_pkg::ST_IDLE && !wel_q;
    endproperty
    a_prot: assert property (p_prot) else $error("protected start ran");

    property p_top;
        decide && seq_go && seq_addr == flash_seq_pkg::TOP_ADDR |=> !seq_q && !wel_q;
    endproperty
    a_top: assert property (p_top) else $error("mode kept past top");

    property p_busy;
        q_valid && ARRAY_READY ##1 !ARRAY_DONE [*2] |-> BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped in flight");

    property p_epe;
        ARRAY_DONE && ARRAY_FAIL |=> PROGRAM_ERASE_ERROR_FLAG;
    endproperty
    a_epe: assert property (p_epe) else $error("error flag not set");

    property p_mask;
        q_valid && ARRAY_OP == flash_seq_pkg::ARR_ERASE_32K |-> ARRAY_ADDR[14:0] == 15'h0000;
    endproperty
    a_mask: assert property (p_mask) else $error("low bits kept");

    property p_so_low;
        irq_active && !rx_end && !BUSY |=> SO_OE && !SO;
    endproperty
    a_so_low: assert property (p_so_low) else $error("SO not low when idle");

    property p_wd;
        decide && wd_ok |=> !wel_q && !seq_q;
    endproperty
    a_wd: assert property (p_wd) else $error("write disable ignored");

    property p_refuse;
        decide && (is_seq || is_er) && !wel_q && !seq_q |=> state_q == flash_seq_pkg::ST_IDLE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command ran without latch");
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // Link pins
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    // Status answer
    input  wire logic so,
    input  wire logic so_oe
);
    // Link clock stands low and select high outside frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // Shifts n bits MSB first from the top of w, mode 0, 80 ns link period
    task automatic frame(input logic [63:0] w, input int n, input bit keep);
        int i;
        cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            si = w[63-i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #40 si = ~si; // Stale data level is not left on the line
        if (!keep) begin
            cs_n = 1'b1;
            #80;
        end
    endtask

    // Status interrupt: 16 clocks, then no clocks until serial out goes low
    task automatic wait_ready(output bit seen, output bit ok);
        int i;
        frame({flash_seq_pkg::OPC_STATUS_IRQ, 56'h0}, 16, 1'b1);
        seen = so_oe && so;
        ok = 1'b0;
        for (i = 0; i < 4000 && !ok; i++) begin
            #10 ok = so_oe && !so;
        end
        cs_n = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        sys_clk = 1'b0, reset = 1'b1, cs_n, sclk, si, so, so_oe;
    logic        array_valid, array_ready = 1'b0, array_done = 1'b0, array_fail = 1'b0;
    logic        error_clear = 1'b0, latch, err, busy, seq_mode;
    logic [7:0]  protect = 8'h00, array_data;
    logic [2:0]  array_op;
    logic [18:0] array_addr;
    logic [29:0] taken[$];
    int          bad_count = 0, compares = 0, hold = 0, seed = 32'h5547;
    bit          core_on = 1'b1, fail_next = 1'b0;
    logic [7:0]  opc [4] = '{flash_seq_pkg::OPC_PAGE_ERASE, flash_seq_pkg::OPC_ERASE_4K,
                             flash_seq_pkg::OPC_ERASE_32K, flash_seq_pkg::OPC_ERASE_64K};

    always #5 sys_clk = ~sys_clk;

    flash_seq_ctrl flash_seq_ctrl_inst (
        .SYS_CLK                 (sys_clk),
        .RESET                   (reset),
        .CS_N                    (cs_n),
        .SCLK                    (sclk),
        .SI                      (si),
        .SO                      (so),
        .SO_OE                   (so_oe),
        .SECTOR_PROTECT          (protect),
        .ARRAY_VALID             (array_valid),
        .ARRAY_READY             (array_ready),
        .ARRAY_OP                (array_op),
        .ARRAY_ADDR              (array_addr),
        .ARRAY_DATA              (array_data),
        .ARRAY_DONE              (array_done),
        .ARRAY_FAIL              (array_fail),
        .ERROR_CLEAR             (error_clear),
        .WRITE_ENABLE_LATCH      (latch),
        .PROGRAM_ERASE_ERROR_FLAG(err),
        .BUSY                    (busy),
        .SEQ_MODE                (seq_mode)
    );

    spi_host_model spi_host_model_inst (
        .cs_n (cs_n),
        .sclk (sclk),
        .si   (si),
        .so   (so),
        .so_oe(so_oe)
    );

    // Array core: records each taken op, finishes it a random while later
    always @(posedge sys_clk) begin
        if (array_valid === 1'b1 && array_ready) begin
            taken.push_back({array_op, array_addr, array_data});
            hold = 200 + ($random(seed) & 63);
        end else if (hold != 0) begin
            hold = hold - 1;
        end
    end
    always @(negedge sys_clk) begin
        array_ready <= core_on && hold == 0;
        array_done  <= hold == 1;
        array_fail  <= fail_next;
    end

    // Expected array address of an erase
    function automatic logic [18:0] erase_addr(input int k, input logic [18:0] a);
        case (k)
            0: return {3'h0, a[15:8], 8'h00};
            1: return a & flash_seq_pkg::MASK_4K;
            2: return a & flash_seq_pkg::MASK_32K;
            default: return a & flash_seq_pkg::MASK_64K;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic send(input logic [63:0] w, input int n);
        spi_host_model_inst.frame(w, n, 1'b0);
    endtask

    task automatic write_enable_latch;
        send({flash_seq_pkg::OPC_WRITE_ENABLE, 56'h0}, 8);
    endtask

    task automatic stat(input logic [1:0] exp);
        repeat (4) @(negedge sys_clk);
        check("latch and mode", {latch, seq_mode}, exp);
    endtask

    task automatic expect_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
        int n;
        for (n = 0; n < 2000 && taken.size() == 0; n++) @(negedge sys_clk);
        check("array op", (taken.size() != 0) ? 32'(taken.pop_front()) : 32'hx, {2'h0, op, a, d});
    endtask

    task automatic idle_wait;
        int n;
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge sys_clk);
    endtask

    // Main sequence
    initial begin
        logic [18:0] a;
        logic [7:0]  d;
        logic [7:0]  exp_d[$];
        int          i;
        bit          seen, ok;
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("reset state", {latch, err, busy, seq_mode, so_oe}, 5'h0);
        send({flash_seq_pkg::OPC_SEQ_A, 24'h000100, 8'h55, 24'h0}, 40);
        stat(2'b00);
        check("refused queue", taken.size(), 0);
        // Stalled core: first cycle plus 15 short cycles fill the queue, the 16th short cycle waits to issue
        core_on = 1'b0;
        write_enable_latch();
        a = {3'h2, 4'h0, 12'($random(seed))};
        d = 8'($random(seed));
        send({flash_seq_pkg::OPC_SEQ_A, 5'h0, a, 8'h3c, d, 16'h0}, 48);
        exp_d.push_back(d);
        for (i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            send({i[0] ? flash_seq_pkg::OPC_SEQ_B : flash_seq_pkg::OPC_SEQ_A, d, 48'h0}, 16);
            exp_d.push_back(d);
        end
        stat(2'b11);
        check("busy while queued", busy, 1'b1);
        core_on = 1'b1;
        for (i = 0; i < 17; i++) begin
            expect_op(3'h0, a + 19'(i), exp_d[i]);
        end
        // Cycle cut off mid-byte
        send({flash_seq_pkg::OPC_SEQ_B, 56'h0}, 12);
        stat(2'b00);
        check("aborted queue", taken.size(), 0);
        write_enable_latch();
        a = {3'h1, 16'($random(seed))};
        send({flash_seq_pkg::OPC_SEQ_B, 5'h0, a, 8'ha5, 24'h0}, 40);
        send({flash_seq_pkg::OPC_WRITE_DISABLE, 56'h0}, 8);
        stat(2'b00);
        expect_op(3'h0, a, 8'ha5);
        // Protected start, top of array, protected neighbour sector
        protect = 8'h08;
        write_enable_latch();
        send({flash_seq_pkg::OPC_SEQ_A, 24'h031234, 8'h11, 24'h0}, 40);
        stat(2'b00);
        check("protected queue", taken.size(), 0);
        protect = 8'h02;
        write_enable_latch();
        send({flash_seq_pkg::OPC_SEQ_A, 24'h07ffff, 8'h77, 24'h0}, 40);
        stat(2'b00);
        expect_op(3'h0, 19'h7ffff, 8'h77);
        write_enable_latch();
        send({flash_seq_pkg::OPC_SEQ_A, 24'h00fffe, 8'h01, 24'h0}, 40);
        send({flash_seq_pkg::OPC_SEQ_B, 8'h02, 48'h0}, 16);
        stat(2'b00);
        expect_op(3'h0, 19'h0fffe, 8'h01);
        expect_op(3'h0, 19'h0ffff, 8'h02);
        protect = 8'h00;
        // Page erase and the three block sizes, the last one failing
        for (i = 0; i < 4; i++) begin
            a = 19'($random(seed));
            write_enable_latch();
            send({opc[i], 5'h0, a, 8'h5a, 24'h0}, (i == 0) ? 32 : 40);
            check("busy on erase", busy, 1'b1);
            stat(2'b00);
            expect_op(3'(i + 1), erase_addr(i, a), 8'hff);
            if (i == 3) check("error before fail", err, 1'b0);
            fail_next = (i == 3); // Only the last erase, now in flight, fails
        end
        idle_wait();
        check("error flag", err, 1'b1);
        fail_next = 1'b0;
        error_clear = 1'b1;
        @(negedge sys_clk);
        error_clear = 1'b0;
        @(negedge sys_clk);
        check("error cleared", err, 1'b0);
        // Short address, then a protected block
        write_enable_latch();
        send({flash_seq_pkg::OPC_ERASE_4K, 56'h0}, 24);
        stat(2'b00);
        protect = 8'h10;
        write_enable_latch();
        send({flash_seq_pkg::OPC_ERASE_64K, 24'h04abcd, 32'h0}, 32);
        stat(2'b00);
        check("refused erase", taken.size(), 0);
        protect = 8'h00;
        // Status interrupt waits out a block erase
        write_enable_latch();
        send({flash_seq_pkg::OPC_ERASE_32K, 24'h018000, 32'h0}, 32);
        spi_host_model_inst.wait_ready(seen, ok);
        check("serial out busy then ready", {seen, ok, busy}, 3'b110);
        expect_op(3'h3, 19'h18000, 8'hff);
        print_verdict();
    end

    // Watchdog against a hung handshake
    initial begin
        #900000;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
